/* design/twou_pkg.sv */
// constants and types for the timer waveform output unit
`default_nettype none
package twou_pkg;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic OUT_RESET = 1'b0;
    // waveform mode codes
    localparam logic [2:0] WM_NORMAL = 3'h0;
    localparam logic [2:0] WM_CLEAR_ON_MATCH = 3'h2;
    localparam logic [2:0] WM_FAST_MAX = 3'h3;
    localparam logic [2:0] WM_FAST_CMPA = 3'h7;
    localparam int TOP_SELECT_POS = 2;
    // output mode codes
    localparam logic [1:0] OM_OFF = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;
    // register offsets of the plain register port
    localparam logic [2:0] REG_CONTROL = 3'h0;
    localparam logic [2:0] REG_COUNTER = 3'h1;
    localparam logic [2:0] REG_COMPARE_A = 3'h2;
    localparam logic [2:0] REG_COMPARE_B = 3'h3;
    localparam logic [2:0] REG_FLAGS = 3'h4;
    localparam logic [2:0] REG_FORCE = 3'h5;
    // control field positions
    localparam int CTL_WM_LSB = 0;
    localparam int CTL_OMA_LSB = 3;
    localparam int CTL_OMB_LSB = 5;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // flag bit positions
    localparam int FLG_OVF = 0;
    localparam int FLG_CMPA = 1;
    localparam int FLG_CMPB = 2;
    localparam int FRC_A = 0;
    localparam int FRC_B = 1;

    typedef enum logic [2:0] {
        WK_NONE = 3'b001,
        WK_NONPWM = 3'b010,
        WK_FAST = 3'b100
    } twou_kind_t;

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] counter_value;
        logic [7:0] cmp_a_act;
        logic [7:0] cmp_b_act;
        logic [7:0] cmp_a_buf;
        logic [7:0] cmp_b_buf;
        logic match_a_p;
        logic match_b_p;
        logic block_p;
        logic overflow_flag;
        logic compare_flag_a;
        logic compare_flag_b;
        logic chan_a_output;
        logic chan_b_output;
        logic pin_a_o;
        logic pin_a_oe;
        logic pin_b_o;
        logic pin_b_oe;
        logic [7:0] rdata;
    } twou_state_t;
endpackage
`default_nettype wire

/* design/twou_top.sv */
// timer waveform output unit: counter, compare, waveform and pin override
// Functional notes
// - output mode bits of each channel choose the output register action at next match.
// - system reset clears each channel's output register to zero.
// - nonzero output mode overrides port value; direction bit still gates visibility.
// - pin override behaves identically in every waveform mode.
// - output mode zero leaves output register unchanged at match, every mode.
// - new output mode acts at next match; force strobe acts now in non-pwm.
// - counter sequence depends only on waveform mode, never on output mode.
// - normal mode counts up each timer tick, wrapping ff to 00.
// - normal and clear-on-match set overflow flag when counter wraps max to zero, except when a compare a match clears it at max.
// - clear-on-match mode clears counter when it matches compare value a.
// - clear-on-match compare a is unbuffered; written below count, wraps past ff.
// - clear-on-match sets compare flag a each time counter reaches top.
// - clear-on-match toggle mode flips channel a output on every match.
// - fast pwm is code 3 or 7; top is ff or compare value a.
// - fast pwm counts up to top, cleared on next timer tick.
// - fast pwm sets overflow flag each time counter reaches top.
// - fast pwm mode two clears on match, sets at top-to-zero; three inverts.
// - fast pwm toggle on channel a only when top-select bit set; not b.
// - fast pwm compare zero gives spike; compare max gives constant level.
// - fast pwm compare registers are double buffered.
// - buffered compare copies to active only at top, never at bottom.
// - match sets compare flag next timer tick; writing one clears it.
// - forced compare updates output only; no flag, no counter change.
//
// Local design decisions: the strobed register port and the register offsets.
`default_nettype none
module twou_top
    import twou_pkg::*;
#(
    // the state layout is fixed; other shapes are refused below
    parameter int COUNT_WIDTH = CNT_W,
    parameter int CHANNELS = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic timer_tick,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic port_value_a,
    input wire logic port_value_b,
    input wire logic compare_pin_direction_a,
    input wire logic compare_pin_direction_b,
    output logic pin_a_o,
    output logic pin_a_oe,
    output logic pin_b_o,
    output logic pin_b_oe,
    output logic overflow_flag,
    output logic compare_flag_a,
    output logic compare_flag_b
);
    import twou_pkg::*;

    twou_state_t s_q;
    twou_state_t s_d;

    // refuse shapes the fixed state layout cannot serve
    if (COUNT_WIDTH != CNT_W) begin : g_width_check
        $error("twou_top: only an 8-bit counter is supported");
    end
    if (CHANNELS != 2) begin : g_channel_check
        $error("twou_top: exactly two compare channels are supported");
    end

    // waveform kind decode, shared by counter and output logic
    function automatic twou_kind_t kind_of(input logic [2:0] wm);
        if (wm == WM_NORMAL || wm == WM_CLEAR_ON_MATCH) begin
            kind_of = WK_NONPWM;
        end else if (wm == WM_FAST_MAX || wm == WM_FAST_CMPA) begin
            kind_of = WK_FAST;
        end else begin
            kind_of = WK_NONE;
        end
    endfunction

    // output action for one channel at a match event
    function automatic logic match_action(input logic cur, input logic [1:0] om,
                                          input twou_kind_t k, input logic tog_ok);
        match_action = cur;
        unique case (om)
            OM_OFF: match_action = cur;
            OM_TOGGLE: match_action = (k == WK_NONPWM || tog_ok) ? ~cur : cur;
            OM_CLEAR: match_action = 1'b0;
            OM_SET: match_action = 1'b1;
        endcase
    endfunction

    // output mode field of channel a, read by the match logic and the pin override
    function automatic logic [1:0] om_a_of(input logic [7:0] ctl);
        om_a_of = ctl[CTL_OMA_LSB +: 2];
    endfunction

    // output mode field of channel b
    function automatic logic [1:0] om_b_of(input logic [7:0] ctl);
        om_b_of = ctl[CTL_OMB_LSB +: 2];
    endfunction

    // strobe decode for one register index
    function automatic logic hits(
        input logic strobe,
        input logic [2:0] addr,
        input logic [2:0] want
    );
        hits = strobe && (addr == want);
    endfunction

    // sticky flag: a hardware set beats a write-one clear in the same cycle
    function automatic logic flag_next(
        input logic cur,
        input logic ev,
        input logic clr
    );
        if (ev) begin
            flag_next = 1'b1;
        end else if (clr) begin
            flag_next = 1'b0;
        end else begin
            flag_next = cur;
        end
    endfunction

    // a match counts unless a counter write blocked it or the mode is unhandled
    function automatic logic match_ok(
        input logic eq,
        input logic blocked,
        input twou_kind_t k
    );
        match_ok = eq && !blocked && (k != WK_NONE);
    endfunction

    // pin value: the compare output replaces the port value whenever its mode is nonzero
    function automatic logic pin_next(
        input logic [1:0] om,
        input logic chan,
        input logic port
    );
        pin_next = (om != OM_OFF) ? chan : port;
    endfunction

    // next non-pwm level of one channel: act only on a real match
    function automatic logic nonpwm_next(
        input logic cur,
        input logic [1:0] om,
        input logic hit
    );
        if (hit) begin
            nonpwm_next = match_action(cur, om, WK_NONPWM, 1'b1);
        end else begin
            nonpwm_next = cur;
        end
    endfunction

    // level a fast pwm channel takes as the counter leaves top
    function automatic logic top_level(input logic [1:0] om);
        top_level = (om == OM_CLEAR);
    endfunction

    // next fast pwm level of one channel; the top action wins over a match at top
    function automatic logic fast_next(
        input logic cur,
        input logic [1:0] om,
        input logic at_top,
        input logic hit,
        input logic ignore,
        input logic tog_ok
    );
        if (at_top && om[1]) begin
            fast_next = top_level(om);
        end else if (hit && !ignore) begin
            fast_next = match_action(cur, om, WK_FAST, tog_ok);
        end else begin
            fast_next = cur;
        end
    endfunction

    logic [2:0] wm;
    logic [1:0] om_a;
    logic [1:0] om_b;
    twou_kind_t kind;
    logic [7:0] top;
    logic at_top;
    logic wrap;
    logic clear_now;
    logic eq_a;
    logic eq_b;
    logic hit_a;
    logic hit_b;
    logic flg_write;
    logic clr_ovf;
    logic clr_cmp_a;
    logic clr_cmp_b;
    logic ovf_ev;
    logic ma_ev;
    logic mb_ev;
    logic frc_a;
    logic frc_b;
    logic fast_ignore_a;

    always_comb begin
        s_d = s_q;
        wm = s_q.ctl[CTL_WM_LSB +: 3];
        om_a = om_a_of(s_q.ctl);
        om_b = om_b_of(s_q.ctl);
        kind = kind_of(wm);
        top = (wm == WM_CLEAR_ON_MATCH || wm == WM_FAST_CMPA) ? s_q.cmp_a_act : CNT_MAX;
        at_top = (s_q.counter_value == top);
        eq_a = (s_q.counter_value == s_q.cmp_a_act);
        eq_b = (s_q.counter_value == s_q.cmp_b_act);
        hit_a = match_ok(eq_a, s_q.block_p, kind);
        hit_b = match_ok(eq_b, s_q.block_p, kind);
        flg_write = hits(reg_write, reg_addr, REG_FLAGS);
        clr_ovf = flg_write && reg_wdata[FLG_OVF];
        clr_cmp_a = flg_write && reg_wdata[FLG_CMPA];
        clr_cmp_b = flg_write && reg_wdata[FLG_CMPB];
        frc_a = hits(reg_write, reg_addr, REG_FORCE) && reg_wdata[FRC_A] && kind == WK_NONPWM;
        frc_b = hits(reg_write, reg_addr, REG_FORCE) && reg_wdata[FRC_B] && kind == WK_NONPWM;
        wrap = 1'b0;
        clear_now = 1'b0;
        ovf_ev = 1'b0;
        ma_ev = 1'b0;
        mb_ev = 1'b0;
        fast_ignore_a = 1'b0;

        if (timer_tick) begin
            s_d.block_p = 1'b0;
            // unhandled modes raise no match and so no flag
            s_d.match_a_p = hit_a;
            s_d.match_b_p = hit_b;
            // flag rises the tick after the match is seen
            ma_ev = s_q.match_a_p;
            mb_ev = s_q.match_b_p;
            unique case (kind)
                WK_NONPWM: begin
                    // unbuffered compare can be skipped past
                    clear_now = (wm == WM_CLEAR_ON_MATCH) && hit_a;
                    wrap = (s_q.counter_value == CNT_MAX) && !clear_now;
                    ovf_ev = wrap;
                    s_d.counter_value = clear_now ? CNT_BOTTOM : s_q.counter_value + 8'h01;
                end
                WK_FAST: begin
                    clear_now = at_top;
                    ovf_ev = at_top;
                    s_d.counter_value = at_top ? CNT_BOTTOM : s_q.counter_value + 8'h01;
                    // reload at top, glitch free period
                    if (at_top) begin
                        s_d.cmp_a_act = s_q.cmp_a_buf;
                        s_d.cmp_b_act = s_q.cmp_b_buf;
                    end
                end
                default: begin
                    // counter held for unhandled codes
                end
            endcase
            // output on match
            if (kind == WK_NONPWM) begin
                s_d.chan_a_output = nonpwm_next(s_q.chan_a_output, om_a, hit_a);
                s_d.chan_b_output = nonpwm_next(s_q.chan_b_output, om_b, hit_b);
            end else if (kind == WK_FAST) begin
                // top action wins over a match at top
                fast_ignore_a = (s_q.cmp_a_act == top) && om_a[1];
                s_d.chan_a_output = fast_next(s_q.chan_a_output, om_a, at_top, hit_a,
                                              fast_ignore_a, wm[TOP_SELECT_POS]);
                s_d.chan_b_output = fast_next(s_q.chan_b_output, om_b, at_top, hit_b,
                                              (s_q.cmp_b_act == top) && om_b[1], 1'b0);
            end
        end

        // force touches only the output
        if (frc_a) begin
            s_d.chan_a_output = match_action(s_q.chan_a_output, om_a, kind, 1'b1);
        end
        if (frc_b) begin
            s_d.chan_b_output = match_action(s_q.chan_b_output, om_b, kind, 1'b0);
        end

        // flags: set wins over a write-one clear
        s_d.overflow_flag = flag_next(s_q.overflow_flag, ovf_ev, clr_ovf);
        s_d.compare_flag_a = flag_next(s_q.compare_flag_a, ma_ev, clr_cmp_a);
        s_d.compare_flag_b = flag_next(s_q.compare_flag_b, mb_ev, clr_cmp_b);

        // register index map: 0 control (mode [2:0], channel a output mode [4:3],
        // channel b output mode [6:5]), 1 counter, 2 compare a, 3 compare b,
        // 4 flags (write one to clear), 5 force strobes; other indices are ignored
        // software writes; a counter write beats counting and blocks next match
        if (reg_write) begin
            unique case (reg_addr)
                REG_CONTROL: s_d.ctl = reg_wdata; // acts at next match
                REG_COUNTER: begin
                    s_d.counter_value = reg_wdata;
                    s_d.block_p = 1'b1;
                    s_d.match_a_p = 1'b0;
                    s_d.match_b_p = 1'b0;
                end
                REG_COMPARE_A: begin
                    // fast pwm waits for top; elsewhere a value below the count is missed
                    s_d.cmp_a_buf = reg_wdata;
                    if (kind != WK_FAST) s_d.cmp_a_act = reg_wdata;
                end
                REG_COMPARE_B: begin
                    // same buffering as compare a
                    s_d.cmp_b_buf = reg_wdata;
                    if (kind != WK_FAST) s_d.cmp_b_act = reg_wdata;
                end
                default: begin
                end
            endcase
        end

        // read data one cycle later; unmapped reads zero
        s_d.rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                REG_CONTROL: s_d.rdata = s_q.ctl;
                REG_COUNTER: s_d.rdata = s_q.counter_value;
                REG_COMPARE_A: s_d.rdata = s_q.cmp_a_buf;
                REG_COMPARE_B: s_d.rdata = s_q.cmp_b_buf;
                REG_FLAGS: s_d.rdata = {5'h00, s_q.compare_flag_b, s_q.compare_flag_a,
                                        s_q.overflow_flag};
                default: s_d.rdata = 8'h00;
            endcase
        end

        // pin override, same in every mode
        s_d.pin_a_o = pin_next(om_a_of(s_d.ctl), s_d.chan_a_output, port_value_a);
        s_d.pin_b_o = pin_next(om_b_of(s_d.ctl), s_d.chan_b_output, port_value_b);
        s_d.pin_a_oe = compare_pin_direction_a;
        s_d.pin_b_oe = compare_pin_direction_b;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0; // output registers start at zero
            s_q.ctl <= CTL_RESET;
            s_q.counter_value <= CNT_RESET;
            s_q.cmp_a_act <= CMP_RESET;
            s_q.cmp_b_act <= CMP_RESET;
            s_q.cmp_a_buf <= CMP_RESET;
            s_q.cmp_b_buf <= CMP_RESET;
            s_q.chan_a_output <= OUT_RESET;
            s_q.chan_b_output <= OUT_RESET;
            // pins start released and low, flags clear, no match pending
            s_q.match_a_p <= 1'b0;
            s_q.match_b_p <= 1'b0;
            s_q.block_p <= 1'b0;
            s_q.overflow_flag <= 1'b0;
            s_q.compare_flag_a <= 1'b0;
            s_q.compare_flag_b <= 1'b0;
            s_q.pin_a_o <= 1'b0;
            s_q.pin_a_oe <= 1'b0;
            s_q.pin_b_o <= 1'b0;
            s_q.pin_b_oe <= 1'b0;
            s_q.rdata <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign pin_a_o = s_q.pin_a_o;
    assign pin_a_oe = s_q.pin_a_oe;
    assign pin_b_o = s_q.pin_b_o;
    assign pin_b_oe = s_q.pin_b_oe;
    assign overflow_flag = s_q.overflow_flag;
    assign compare_flag_a = s_q.compare_flag_a;
    assign compare_flag_b = s_q.compare_flag_b;
endmodule
`default_nettype wire

/* tb/twou_pin_model.sv */
// pad model for a compare output pin with an external pull-up
`default_nettype none
module twou_pin_model #(
    parameter logic PULL = 1'b1
) (
    input wire logic o,
    input wire logic oe,
    output wire logic pad
);
    timeunit 1ns;
    timeprecision 100ps;
    // a released pad sits at the pull level, never at the last driven value
    assign pad = oe ? o : PULL;
endmodule
`default_nettype wire

/* tb/twou_chk_assertions.sv */
// port-level assertions for the timer waveform output unit
`default_nettype none
module twou_chk
    import twou_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic timer_tick,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic compare_pin_direction_a,
    input wire logic pin_a_o,
    input wire logic pin_b_o,
    input wire logic pin_a_oe,
    input wire logic overflow_flag,
    input wire logic compare_flag_a
);
    timeunit 1ns;
    timeprecision 100ps;
    logic flg_wr;
    assign flg_wr = reg_write && reg_addr == REG_FLAGS;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_clears: assert property (
        $fell(reset) |-> !pin_a_o && !pin_b_o && !compare_flag_a)
        else $error("outputs not clear after reset");
    a_oe_follows: assert property (
        !$past(reset) |-> pin_a_oe == $past(compare_pin_direction_a))
        else $error("pin a enable does not follow direction");
    a_ovf_sticky: assert property (
        overflow_flag && !(flg_wr && reg_wdata[FLG_OVF]) |=> overflow_flag)
        else $error("overflow flag dropped");
    a_cmpa_sticky: assert property (
        compare_flag_a && !(flg_wr && reg_wdata[FLG_CMPA]) |=> compare_flag_a)
        else $error("compare flag a dropped");
    a_ovf_needs_tick: assert property (
        !timer_tick && !overflow_flag |=> !overflow_flag)
        else $error("overflow flag set without a tick");
    a_cmpa_needs_tick: assert property (
        !timer_tick && !compare_flag_a |=> !compare_flag_a)
        else $error("compare flag a set without a tick");
    a_ovf_clear_one: assert property (
        flg_wr && reg_wdata[FLG_OVF] && !timer_tick |=> !overflow_flag)
        else $error("overflow flag not cleared");
    a_cmpa_clear_one: assert property (
        flg_wr && reg_wdata[FLG_CMPA] && !timer_tick |=> !compare_flag_a)
        else $error("compare flag a not cleared");
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the timer waveform output unit
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
$display("unexpected %s exp %0h got %0h", n, e, s); miscompares++; end end
module tb
    import twou_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic timer_tick = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic port_value_a = 1'b0;
    logic port_value_b = 1'b0;
    logic compare_pin_direction_a = 1'b0;
    logic compare_pin_direction_b = 1'b0;
    logic [7:0] reg_rdata, v;
    logic pin_a_o, pin_a_oe, pin_b_o, pin_b_oe, overflow_flag, compare_flag_a, compare_flag_b;
    wire logic pad_a, pad_b;
    int miscompares = 0;
    int n_checks = 0;
    int g, c, e;
    twou_top uut (.clk(clk), .reset(reset), .timer_tick(timer_tick), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .port_value_a(port_value_a), .port_value_b(port_value_b),
        .compare_pin_direction_a(compare_pin_direction_a),
        .compare_pin_direction_b(compare_pin_direction_b),
        .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe),
        .overflow_flag(overflow_flag), .compare_flag_a(compare_flag_a),
        .compare_flag_b(compare_flag_b));
    twou_pin_model pin_a (.o(pin_a_o), .oe(pin_a_oe), .pad(pad_a));
    twou_pin_model pin_b (.o(pin_b_o), .oe(pin_b_oe), .pad(pad_b));
    initial forever #2.5 clk = ~clk;
    task report_and_stop;
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task wt2;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // exactly n timer ticks, then the timer stands still
    task tk(input int n);
        @(posedge clk);
        timer_tick <= 1'b1;
        repeat (n) @(posedge clk);
        timer_tick <= 1'b0;
        #1;
    endtask
    // length of the next complete phase of pin a at level lv
    task phase(input logic lv, output int n);
        int k;
        k = 0;
        while (pin_a_o === lv && k < 900) begin @(posedge clk); #1; k++; end
        while (pin_a_o !== lv && k < 900) begin @(posedge clk); #1; k++; end
        n = 0;
        while (pin_a_o === lv && n < 900) begin @(posedge clk); #1; n++; end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop;
    end
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("pin a", 1'b0, pin_a_o)
        `CHK("pad a", 1'b1, pad_a)
        `CHK("pad b", 1'b1, pad_b)
        @(posedge clk) compare_pin_direction_a <= 1'b1;
        compare_pin_direction_b <= 1'b1;
        wt2;
        `CHK("pad a", 1'b0, pad_a)
        @(posedge clk) port_value_a <= 1'b1;
        wt2;
        `CHK("pin a", 1'b1, pin_a_o)
        for (int m = 3; m > 0; m--) begin
            wr(REG_CONTROL, {3'h0, m[1:0], 3'h0});
            wr(REG_FORCE, 8'h01);
            @(posedge clk);
            #1;
            `CHK("forced a", m != 2, pin_a_o)
        end
        `CHK("flag a", 1'b0, compare_flag_a)
        rd(REG_COUNTER, v);
        `CHK("counter", 8'h00, v)
        wr(REG_CONTROL, 8'h00);
        wr(REG_COUNTER, 8'hfe);
        tk(1);
        rd(REG_COUNTER, v);
        `CHK("counter", 8'hff, v)
        `CHK("overflow", 1'b0, overflow_flag)
        tk(1);
        `CHK("overflow", 1'b1, overflow_flag)
        rd(REG_COUNTER, v);
        `CHK("counter", 8'h00, v)
        wr(REG_FLAGS, 8'h07);
        wr(REG_COMPARE_A, 8'h03);
        wr(REG_CONTROL, 8'h0a);
        @(posedge clk) timer_tick <= 1'b1;
        phase(1'b1, g);
        `CHK("toggle high", 4, g)
        phase(1'b0, g);
        `CHK("toggle low", 4, g)
        `CHK("flag a", 1'b1, compare_flag_a)
        `CHK("flag b", 1'b1, compare_flag_b)
        `CHK("overflow", 1'b0, overflow_flag)
        @(posedge clk) timer_tick <= 1'b0;
        wr(REG_COUNTER, 8'h10);
        wr(REG_COMPARE_A, 8'h05);
        wr(REG_FLAGS, 8'h07);
        tk(8'hef);
        `CHK("overflow", 1'b0, overflow_flag)
        tk(1);
        `CHK("overflow", 1'b1, overflow_flag)
        wr(REG_COMPARE_A, 8'h40);
        wr(REG_FLAGS, 8'h07);
        for (int m = 2; m < 4; m++) begin
            wr(REG_CONTROL, {3'h0, m[1:0], WM_FAST_MAX});
            @(posedge clk) timer_tick <= 1'b1;
            e = (m == 2) ? 8'h41 : 8'hbf;
            phase(1'b1, g);
            `CHK("pwm high", e, g)
            phase(1'b0, g);
            `CHK("pwm low", 256 - e, g)
        end
        `CHK("overflow", 1'b1, overflow_flag)
        wr(REG_COMPARE_A, 8'h05);
        @(posedge clk) port_value_b <= 1'b1;
        wr(REG_CONTROL, 8'h2f);
        repeat (3) phase(1'b1, g);
        `CHK("toggle high", 6, g)
        `CHK("pin b", 1'b0, pin_b_o)
        `CHK("pad b", 1'b0, pad_b)
        wr(REG_CONTROL, 8'h0b);
        wt2;
        v[0] = pin_a_o;
        c = 0;
        repeat (300) begin
            @(posedge clk);
            #1;
            if (pin_a_o !== v[0]) c++;
        end
        `CHK("toggles", 0, c)
        wr(REG_COMPARE_A, 8'hff);
        wr(REG_CONTROL, 8'h13);
        repeat (260) @(posedge clk);
        #1;
        c = 0;
        repeat (300) begin
            @(posedge clk);
            #1;
            if (pin_a_o !== 1'b1) c++;
        end
        `CHK("pwm max", 0, c)
        @(posedge clk) timer_tick <= 1'b0;
        wr(REG_CONTROL, 8'h01);
        wr(REG_COUNTER, 8'h33);
        tk(20);
        rd(REG_COUNTER, v);
        `CHK("counter", 8'h33, v)
        report_and_stop;
    end
endmodule
bind twou_top twou_chk chk (.clk(clk), .reset(reset), .timer_tick(timer_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .compare_pin_direction_a(compare_pin_direction_a), .pin_a_o(pin_a_o),
    .pin_b_o(pin_b_o), .pin_a_oe(pin_a_oe), .overflow_flag(overflow_flag),
    .compare_flag_a(compare_flag_a));
`default_nettype wire
